/* File: bench/core_memmap_active_data_pointer_chk.sv */
`timescale 1ns/100ps

module core_memmap_active_data_pointer_chk (
   input wire i_clk,
   input wire i_rst,
   input wire i_req,
   input wire i_host_only,
   input wire o_ready,
   input wire o_done,
   input wire [15:0] o_xmem_addr,
   input wire o_xmem_sram_sel,
   input wire o_xmem_flash_sel,
   input wire o_xmem_rd,
   input wire o_periph_wr,
   input wire o_host_ack,
   input wire o_timer_tick,
   input wire [1:0] o_phase
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   a_done_one_clk: assert property (o_done |=> !o_done)
      else $error("done lasted more than one clock");
   a_take_busy: assert property (i_req && o_ready && !i_host_only |=> !o_ready)
      else $error("ready stayed high after a request was taken");
   a_host_refuse: assert property (o_ready && i_host_only |=> o_ready && !o_done)
      else $error("request taken while the processor is unused");
   a_xrd_len: assert property ($rose(o_xmem_rd) |-> o_xmem_rd [*4] ##1 !o_xmem_rd)
      else $error("external read strobe not four clocks long");
   a_sram_range: assert property (o_xmem_sram_sel |->
      o_xmem_addr < 16'h0400 && !o_xmem_flash_sel)
      else $error("scratch memory selected outside its range");
   a_flash_range: assert property (o_xmem_flash_sel |-> o_xmem_addr[15:11] == 5'h10)
      else $error("secondary flash selected outside its range");
   a_phase_step: assert property ($changed(o_phase) |->
      o_phase == $past(o_phase) + 2'h1 ##1 $stable(o_phase) ##1 $changed(o_phase))
      else $error("phase does not advance every two clocks");
   a_tick_gap: assert property (o_timer_tick |=> !o_timer_tick [*7])
      else $error("timer ticks closer than four system clocks");
   a_wr_pulse: assert property (o_periph_wr |=> !o_periph_wr)
      else $error("peripheral write strobe longer than one clock");
   a_ack_pulse: assert property (o_host_ack |=> !o_host_ack)
      else $error("host acknowledge longer than one clock");
endmodule

bind core_memmap_active_data_pointer core_memmap_active_data_pointer_chk core_memmap_active_data_pointer_chk_inst (
   .i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_host_only(i_host_only), .o_ready(o_ready),
   .o_done(o_done), .o_xmem_addr(o_xmem_addr), .o_xmem_sram_sel(o_xmem_sram_sel),
   .o_xmem_flash_sel(o_xmem_flash_sel), .o_xmem_rd(o_xmem_rd), .o_periph_wr(o_periph_wr),
   .o_host_ack(o_host_ack), .o_timer_tick(o_timer_tick), .o_phase(o_phase)
);

/* File: bench/core_memmap_active_data_pointer_tb.sv */
`timescale 1ns/100ps
`include "core_regs.vh"

module core_memmap_active_data_pointer_tb;
   reg i_clk = 1'b0, i_rst = 1'b1, i_req = 1'b0, i_host_only = 1'b0, i_host_req = 1'b0;
   reg i_host_wr = 1'b0, i_timer_fast = 1'b0;
   reg [3:0] i_op = 4'h0;
   reg [7:0] i_addr = 8'h00, i_addr2 = 8'h00, i_wdata = 8'h00, i_host_addr = 8'h00;
   reg [7:0] i_host_wdata = 8'h00;
   reg [15:0] i_wdata16 = 16'h0000;
   wire o_ready, o_done, o_code_rd, o_xmem_sram_sel, o_xmem_flash_sel, o_xmem_rd, o_xmem_wr;
   wire o_periph_rd, o_periph_wr, o_host_ack, o_timer_tick;
   wire [7:0] o_rdata, o_xmem_wdata, i_xmem_rdata, o_periph_addr, o_periph_wdata;
   wire [7:0] i_periph_rdata, o_host_rdata;
   wire [15:0] o_code_addr, o_xmem_addr;
   wire [1:0] o_phase;
   integer miscompares = 0, tests_run = 0, clks, fetches;
   reg [7:0] rd;
   reg [15:0] xaddr, faddr;
   reg [1:0] xsel;
   reg [7:0] xwd;
   reg started;

   core_memmap_active_data_pointer core_memmap_active_data_pointer_inst (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req),
      .i_op(i_op), .i_addr(i_addr), .i_addr2(i_addr2), .i_wdata(i_wdata), .i_wdata16(i_wdata16),
      .o_ready(o_ready), .o_done(o_done), .o_rdata(o_rdata), .o_code_addr(o_code_addr),
      .o_code_rd(o_code_rd), .o_xmem_addr(o_xmem_addr), .o_xmem_sram_sel(o_xmem_sram_sel),
      .o_xmem_flash_sel(o_xmem_flash_sel), .o_xmem_rd(o_xmem_rd), .o_xmem_wr(o_xmem_wr),
      .o_xmem_wdata(o_xmem_wdata), .i_xmem_rdata(i_xmem_rdata), .o_periph_addr(o_periph_addr),
      .o_periph_rd(o_periph_rd), .o_periph_wr(o_periph_wr), .o_periph_wdata(o_periph_wdata),
      .i_periph_rdata(i_periph_rdata), .i_host_only(i_host_only), .i_host_req(i_host_req),
      .i_host_wr(i_host_wr), .i_host_addr(i_host_addr), .i_host_wdata(i_host_wdata),
      .o_host_ack(o_host_ack), .o_host_rdata(o_host_rdata), .i_timer_fast(i_timer_fast),
      .o_timer_tick(o_timer_tick), .o_phase(o_phase));

   mem_model mem_model_inst (.i_clk(i_clk), .i_xaddr(o_xmem_addr), .i_sram_sel(o_xmem_sram_sel),
      .i_flash_sel(o_xmem_flash_sel), .i_xrd(o_xmem_rd), .i_paddr(o_periph_addr),
      .i_prd(o_periph_rd), .i_pwr(o_periph_wr), .i_pwdata(o_periph_wdata),
      .o_xdata(i_xmem_rdata), .o_pdata(i_periph_rdata));

   always #20 i_clk = ~i_clk;

   task stop_test;
      begin
         if (miscompares == 0 && tests_run > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask

   task check(input [15:0] got, input [15:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
         end
      end
   endtask

   task step;
      begin
         @(posedge i_clk);
         #1;
      end
   endtask

   // One operation, timed from its first fetch to done; an idle instruction cycle follows.
   task run(input [3:0] op, input [7:0] a, input [7:0] a2, input [15:0] wd);
      integer n;
      begin
         step;
         i_op = op;
         i_addr = a;
         i_addr2 = a2;
         i_wdata = wd[7:0];
         i_wdata16 = wd;
         i_req = 1'b1;
         step;
         i_req = 1'b0;
         clks = 0;
         fetches = 0;
         started = 1'b0;
         xaddr = 16'hFFFF;
         xsel = 2'b11;
         xwd = 8'h00;
         for (n = 0; n < 80 && o_done !== 1'b1; n = n + 1) begin
            if (o_code_rd === 1'b1 && !started)
               faddr = o_code_addr;
            if (o_code_rd === 1'b1)
               fetches = fetches + 1;
            if (o_code_rd === 1'b1)
               started = 1'b1;
            if (started)
               clks = clks + 1;
            if (o_xmem_rd === 1'b1 || o_xmem_wr === 1'b1) begin
               xaddr = o_xmem_addr;
               xsel = {o_xmem_flash_sel, o_xmem_sram_sel};
            end
            if (o_xmem_wr === 1'b1)
               xwd = o_xmem_wdata;
            step;
         end
         check(o_done, 1'b1);
         rd = o_rdata;
         repeat (8) step;
      end
   endtask

   task host(input wr, input [7:0] a, input [7:0] d);
      integer n;
      begin
         step;
         i_host_req = 1'b1;
         i_host_wr = wr;
         i_host_addr = a;
         i_host_wdata = d;
         for (n = 0; n < 40 && o_host_ack !== 1'b1; n = n + 1)
            step;
         check(o_host_ack, 1'b1);
         i_host_req = 1'b0;
      end
   endtask

   task t_reset;
      begin
         run(`OP_DIR_RD, 8'h86, 8'h00, 16'h0000);
         check(rd, 8'h00);
         check(faddr, 16'h0000);
      end
   endtask

   task t_regs;
      integer k;
      reg [31:0] pv;
      begin
         pv = 32'h01238005;
         for (k = 0; k < 4; k = k + 1)
            run(`OP_DIR_WR, 8'h82 + k[7:0], 8'h00, {8'h00, pv[8*k +: 8]});
         for (k = 0; k < 4; k = k + 1) begin
            run(`OP_DIR_RD, 8'h82 + k[7:0], 8'h00, 16'h0000);
            check(rd, pv[8*k +: 8]);
         end
         run(`OP_DIR_WR, 8'h86, 8'h00, 16'h00FF);
         run(`OP_DIR_RD, 8'h86, 8'h00, 16'h0000);
         check(rd, 8'h01);
      end
   endtask

   task t_xdata;
      begin
         run(`OP_XDATA_RD, 8'h00, 8'h00, 16'h0000);
         check(xaddr, 16'h0123);
         check(xsel, 2'b01);
         check(rd, 8'h79);
         check(clks, 16);
         run(`OP_DIR_INC, 8'h86, 8'h00, 16'h0000);
         run(`OP_DIR_RD, 8'h86, 8'h00, 16'h0000);
         check(rd, 8'h00);
         run(`OP_XDATA_RD, 8'h00, 8'h00, 16'h0000);
         check(xaddr, 16'h8005);
         check(xsel, 2'b10);
         check(rd, 8'hC6);
         run(`OP_XDATA_WR, 8'h00, 8'h00, 16'h005D);
         check(xaddr, 16'h8005);
         check(xsel, 2'b10);
         check(xwd, 8'h5D);
      end
   endtask

   task t_ptr;
      begin
         run(`OP_PTR_INC, 8'h00, 8'h00, 16'h0000);
         run(`OP_DIR_INC, 8'h86, 8'h00, 16'h0000);
         run(`OP_PTR_LOAD, 8'h00, 8'h00, 16'h03FF);
         run(`OP_DIR_RD, 8'h82, 8'h00, 16'h0000);
         check(rd, 8'h06);
         run(`OP_DIR_RD, 8'h84, 8'h00, 16'h0000);
         check(rd, 8'hFF);
         run(`OP_DIR_RD, 8'h85, 8'h00, 16'h0000);
         check(rd, 8'h03);
      end
   endtask

   task t_ram;
      begin
         run(`OP_DIR_WR, 8'hA0, 8'h00, 16'h0011);
         run(`OP_IND_WR, 8'hA0, 8'h00, 16'h0022);
         run(`OP_DIR_WR, 8'h10, 8'h00, 16'h0033);
         run(`OP_DIR_RD, 8'hA0, 8'h00, 16'h0000);
         check(rd, 8'h11);
         run(`OP_IND_RD, 8'hA0, 8'h00, 16'h0000);
         check(rd, 8'h22);
         run(`OP_MOV_DD, 8'h10, 8'h20, 16'h0000);
         check(clks, 24);
         check(fetches, 3);
         run(`OP_IND_RD, 8'h20, 8'h00, 16'h0000);
         check(rd, 8'h33);
         run(`OP_MULTIPLY, 8'h00, 8'h00, 16'h0000);
         check(clks, 40);
         check(fetches, 1);
      end
   endtask

   task t_host;
      integer n, seen;
      begin
         host(1'b0, 8'hA0, 8'h00);
         check(o_host_rdata, 8'h11);
         i_host_only = 1'b1;
         i_op = `OP_DIR_WR;
         i_addr = 8'h30;
         i_req = 1'b1;
         seen = 0;
         for (n = 0; n < 20; n = n + 1) begin
            step;
            if (o_done !== 1'b0 || o_code_rd !== 1'b0)
               seen = 1;
         end
         i_req = 1'b0;
         check(seen, 0);
         host(1'b1, 8'hA1, 8'h44);
         i_host_only = 1'b0;
         run(`OP_DIR_RD, 8'hA1, 8'h00, 16'h0000);
         check(rd, 8'h44);
      end
   endtask

   // The first interval after a mode change may be odd, so 60 clocks pass and then the interval between the next two ticks is measured.
   task t_timer;
      integer n, k;
      begin
         for (k = 0; k < 2; k = k + 1) begin
            i_timer_fast = k[0];
            repeat (60) step;
            for (n = 0; n < 60 && o_timer_tick !== 1'b1; n = n + 1)
               step;
            step;
            for (n = 1; n < 60 && o_timer_tick !== 1'b1; n = n + 1)
               step;
            check(n, k ? 8 : 24);
         end
      end
   endtask

   initial begin
      repeat (16) @(posedge i_clk);
      #1;
      i_rst = 1'b0;
      t_reset;
      t_regs;
      t_xdata;
      t_ptr;
      t_ram;
      t_host;
      t_timer;
      stop_test;
   end

   initial begin
      #(40 * 20000);
      miscompares = miscompares + 1;
      stop_test;
   end
endmodule

/* File: bench/mem_model.sv */
`timescale 1ns/100ps

module mem_model (
   input wire i_clk,
   input wire [15:0] i_xaddr,
   input wire i_sram_sel,
   input wire i_flash_sel,
   input wire i_xrd,
   input wire [7:0] i_paddr,
   input wire i_prd,
   input wire i_pwr,
   input wire [7:0] i_pwdata,
   output wire [7:0] o_xdata,
   output wire [7:0] o_pdata
);
   reg [7:0] regs [0:255];
   reg [7:0] xlast = 8'h00;
   reg [7:0] plast = 8'h00;
   wire [7:0] xval = i_flash_sel ? (i_xaddr[7:0] ^ 8'hC3) :
      i_sram_sel ? (i_xaddr[7:0] ^ 8'h5A) : 8'hEE;

   // An idle bus shows the inverse of its last value, so stale data never passes as fresh.
   assign o_xdata = i_xrd ? xval : ~xlast;
   assign o_pdata = i_prd ? regs[i_paddr] : ~plast;

   always @(posedge i_clk) begin
      if (i_xrd)
         xlast <= xval;
      if (i_prd)
         plast <= regs[i_paddr];
      if (i_pwr)
         regs[i_paddr] <= i_pwdata;
   end
endmodule

/* File: logic/core_memmap_active_data_pointer.v */
`timescale 1ns/100ps
`include "core_regs.vh"

// What this block does
// R01: After reset, fetch code from 64K program flash.
// R02: Secondary 2K flash sits in external data space.
// R03: Software avoids reserved one-time region ranges.
// R04: 1K scratch SRAM sits in external data space.
// R05: Lower internal RAM direct/indirect, upper indirect only.
// R06: Special registers overlay upper half, direct only.
// R07: Provide a 16-bit data pointer.
// R08: First pointer at 82h low, 83h high.
// R09: Second pointer at 84h low, 85h high.
// R10: Bit 0 of 86h selects pointer; rest unused.
// R11: Pointer instructions use and update selected pointer.
// R12: Incrementing 86h toggles the active pointer.
// R13: Instruction cycle is four CPU phases.
// R14: System clock is oscillator divided by two.
// R15: External read 8 clocks, direct move 12.
// R16: Instructions take one to five instruction cycles.
// R17: Bytes equal fetches; multiply takes extra cycles.
// R18: Timers tick every 12 clocks, or 4.
// R19: Host port reaches all peripherals, not processor.
// R20: Host may drive peripherals with processor unused.
// R21: Opcode behaviour follows the compatible classic core.
// R22: Pointer select clears to first pointer on reset.
module core_memmap_active_data_pointer (
   input wire i_clk,
   input wire i_rst,
   input wire i_req,
   input wire [3:0] i_op,
   input wire [7:0] i_addr,
   input wire [7:0] i_addr2,
   input wire [7:0] i_wdata,
   input wire [15:0] i_wdata16,
   output reg o_ready,
   output reg o_done,
   output reg [7:0] o_rdata,
   output reg [15:0] o_code_addr,
   output reg o_code_rd,
   output reg [15:0] o_xmem_addr,
   output reg o_xmem_sram_sel,
   output reg o_xmem_flash_sel,
   output reg o_xmem_rd,
   output reg o_xmem_wr,
   output reg [7:0] o_xmem_wdata,
   input wire [7:0] i_xmem_rdata,
   output reg [7:0] o_periph_addr,
   output reg o_periph_rd,
   output reg o_periph_wr,
   output reg [7:0] o_periph_wdata,
   input wire [7:0] i_periph_rdata,
   input wire i_host_only,
   input wire i_host_req,
   input wire i_host_wr,
   input wire [7:0] i_host_addr,
   input wire [7:0] i_host_wdata,
   output reg o_host_ack,
   output reg [7:0] o_host_rdata,
   input wire i_timer_fast,
   output wire o_timer_tick,
   output wire [1:0] o_phase
);

   localparam HOST_IDLE = 2'b00;
   localparam HOST_WAIT = 2'b01;
   localparam HOST_ACK = 2'b10;

   reg [7:0] iram_q [0:255];
   reg [15:0] first_data_pointer_q;
   reg [15:0] second_data_pointer_q;
   reg sel_q;
   reg [15:0] pc_q;
   reg pend_q;
   reg [3:0] op_q;
   reg [7:0] addr_q;
   reg [7:0] addr2_q;
   reg [7:0] wdata_q;
   reg [15:0] wdata16_q;
   reg [7:0] data_q;
   reg [1:0] host_q;
   reg [7:0] wr_val;

   wire tick;
   wire busy;
   wire last;
   wire [2:0] icycle;
   wire end_edge;
   wire accept;
   wire cyc_start;
   wire [2:0] next_ic;
   wire next_last;
   wire core_bus;
   wire [15:0] active_data_pointer;
   wire [7:0] wr_addr;
   wire dir_reads;
   wire dir_writes;
   wire [1:0] xsel;

   function [2:0] op_bytes;
      input [3:0] op;
      begin
         case (op)
            `OP_DIR_RD, `OP_DIR_WR, `OP_DIR_INC: op_bytes = 3'h2;
            `OP_PTR_LOAD, `OP_MOV_DD: op_bytes = 3'h3; // [R21]
            default: op_bytes = 3'h1;
         endcase
      end
   endfunction

   function [2:0] op_cycles;
      input [3:0] op;
      begin
         case (op)
            `OP_DIR_RD, `OP_DIR_WR, `OP_DIR_INC: op_cycles = 3'h2;
            `OP_XDATA_RD, `OP_XDATA_WR: op_cycles = 3'h2; // [R15]
            `OP_PTR_LOAD, `OP_PTR_INC: op_cycles = 3'h3;
            `OP_MOV_DD: op_cycles = 3'h3; // [R15]
            `OP_MULTIPLY: op_cycles = 3'h5; // [R17]
            default: op_cycles = 3'h1;
         endcase
      end
   endfunction

   function is_local;
      input [7:0] a;
      begin
         is_local = (a >= `ADDR_PTR0_LOW) && (a <= `ADDR_PTR_SEL);
      end
   endfunction

   function [7:0] local_read;
      input [7:0] a;
      begin
         case (a)
            `ADDR_PTR0_LOW: local_read = first_data_pointer_q[7:0]; // [R08]
            `ADDR_PTR0_HIGH: local_read = first_data_pointer_q[15:8];
            `ADDR_PTR1_LOW: local_read = second_data_pointer_q[7:0]; // [R09]
            `ADDR_PTR1_HIGH: local_read = second_data_pointer_q[15:8];
            default: local_read = {7'h00, sel_q}; // [R10]
         endcase
      end
   endfunction

   function [1:0] xdecode;
      input [15:0] a;
      begin
         xdecode[0] = (a - `XSRAM_BASE) < `XSRAM_SIZE; // [R04]
         xdecode[1] = (a >= `XFLASH_BASE) && ((a - `XFLASH_BASE) < `XFLASH_SIZE); // [R02]
      end
   endfunction

   cycle_sequencer cycle_sequencer_inst (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_start(accept),
      .i_cycles(op_cycles(op_q)),
      .o_tick(tick),
      .o_phase(o_phase),
      .o_busy(busy),
      .o_icycle(icycle),
      .o_last(last)
   );

   timer_prescaler timer_prescaler_inst (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_tick(tick),
      .i_fast(i_timer_fast),
      .o_tick(o_timer_tick)
   );

   assign end_edge = tick & (o_phase == `LAST_PHASE);
   // The host must be idle before an access starts so the two never share the bus.
   assign accept = pend_q & end_edge & ~busy & (host_q == HOST_IDLE);
   assign cyc_start = accept | (end_edge & busy & ~last);
   assign next_ic = accept ? 3'h0 : icycle + 3'h1;
   assign next_last = ((next_ic + 3'h1) == op_cycles(op_q));
   assign core_bus = busy & last;
   assign active_data_pointer = sel_q ? second_data_pointer_q : first_data_pointer_q; // [R11]
   assign wr_addr = (op_q == `OP_MOV_DD) ? addr2_q : addr_q;
   assign dir_reads = (op_q == `OP_DIR_RD) | (op_q == `OP_DIR_INC) | (op_q == `OP_MOV_DD);
   assign dir_writes = (op_q == `OP_DIR_WR) | (op_q == `OP_DIR_INC) | (op_q == `OP_MOV_DD);
   assign xsel = xdecode(active_data_pointer);

   always @* begin
      case (op_q)
         `OP_DIR_INC: wr_val = data_q + 8'h01; // [R12]
         `OP_MOV_DD: wr_val = data_q;
         default: wr_val = wdata_q;
      endcase
   end

   always @(posedge i_clk) begin
      if (i_rst) begin
         first_data_pointer_q <= `DP_RESET;
         second_data_pointer_q <= `DP_RESET;
         sel_q <= `SEL_RESET; // [R22]
         pc_q <= `CODE_RESET; // [R01]
         pend_q <= 1'b0;
         op_q <= `OP_NOP;
         addr_q <= 8'h00;
         addr2_q <= 8'h00;
         wdata_q <= 8'h00;
         wdata16_q <= 16'h0000;
         data_q <= 8'h00;
         host_q <= HOST_IDLE;
         o_ready <= 1'b1;
         o_done <= 1'b0;
         o_rdata <= 8'h00;
         o_code_addr <= `CODE_RESET;
         o_code_rd <= 1'b0;
         o_xmem_addr <= 16'h0000;
         o_xmem_sram_sel <= 1'b0;
         o_xmem_flash_sel <= 1'b0;
         o_xmem_rd <= 1'b0;
         o_xmem_wr <= 1'b0;
         o_xmem_wdata <= 8'h00;
         o_periph_addr <= 8'h00;
         o_periph_rd <= 1'b0;
         o_periph_wr <= 1'b0;
         o_periph_wdata <= 8'h00;
         o_host_ack <= 1'b0;
         o_host_rdata <= 8'h00;
      end else begin
         o_done <= 1'b0;
         o_code_rd <= 1'b0;
         o_xmem_wr <= 1'b0;
         o_periph_wr <= 1'b0;
         o_host_ack <= 1'b0;
         // The processor takes no work while the host owns the peripherals.
         if (i_req && o_ready && !i_host_only) begin // [R20]
            op_q <= i_op;
            addr_q <= i_addr;
            addr2_q <= i_addr2;
            wdata_q <= i_wdata;
            wdata16_q <= i_wdata16;
            pend_q <= 1'b1;
            o_ready <= 1'b0;
         end
         if (accept) begin
            pend_q <= 1'b0;
         end
         if (cyc_start && (next_ic < op_bytes(op_q))) begin // [R17]
            o_code_rd <= 1'b1;
            o_code_addr <= pc_q; // [R01]
            pc_q <= pc_q + 16'h0001;
         end
         if (cyc_start && next_last) begin
            if (dir_reads && addr_q[7] && !is_local(addr_q)) begin // [R06]
               o_periph_addr <= addr_q;
               o_periph_rd <= 1'b1;
            end
            if (op_q == `OP_XDATA_RD) begin // [R07]
               o_xmem_addr <= active_data_pointer;
               o_xmem_sram_sel <= xsel[0];
               o_xmem_flash_sel <= xsel[1];
               o_xmem_rd <= 1'b1;
            end
         end
         if (core_bus && tick && (o_phase == 2'h1)) begin
            o_periph_rd <= 1'b0;
            o_xmem_rd <= 1'b0;
            if (dir_reads) begin
               if (!addr_q[7]) begin
                  data_q <= iram_q[addr_q]; // [R05]
               end else if (is_local(addr_q)) begin
                  data_q <= local_read(addr_q);
               end else begin
                  data_q <= i_periph_rdata; // [R06]
               end
            end else if (op_q == `OP_IND_RD) begin
               data_q <= iram_q[addr_q]; // [R05]
            end else if (op_q == `OP_XDATA_RD) begin
               data_q <= i_xmem_rdata;
            end
         end
         if (core_bus && tick && (o_phase == 2'h2)) begin
            if (dir_writes) begin
               if (!wr_addr[7]) begin
                  iram_q[wr_addr] <= wr_val; // [R05]
               end else if (is_local(wr_addr)) begin
                  case (wr_addr)
                     `ADDR_PTR0_LOW: first_data_pointer_q[7:0] <= wr_val; // [R08]
                     `ADDR_PTR0_HIGH: first_data_pointer_q[15:8] <= wr_val;
                     `ADDR_PTR1_LOW: second_data_pointer_q[7:0] <= wr_val; // [R09]
                     `ADDR_PTR1_HIGH: second_data_pointer_q[15:8] <= wr_val;
                     default: sel_q <= wr_val[`SEL_BIT]; // [R10] [R12]
                  endcase
               end else begin
                  o_periph_addr <= wr_addr; // [R06]
                  o_periph_wdata <= wr_val;
                  o_periph_wr <= 1'b1;
               end
            end
            if (op_q == `OP_IND_WR) begin
               iram_q[addr_q] <= wdata_q; // [R05]
            end
            if (op_q == `OP_XDATA_WR) begin
               o_xmem_addr <= active_data_pointer; // [R11]
               o_xmem_sram_sel <= xsel[0];
               o_xmem_flash_sel <= xsel[1];
               o_xmem_wdata <= wdata_q;
               o_xmem_wr <= 1'b1;
            end
            if ((op_q == `OP_PTR_LOAD) || (op_q == `OP_PTR_INC)) begin
               if (sel_q) begin // [R11]
                  second_data_pointer_q <= (op_q == `OP_PTR_LOAD) ? wdata16_q :
                     second_data_pointer_q + 16'h0001;
               end else begin
                  first_data_pointer_q <= (op_q == `OP_PTR_LOAD) ? wdata16_q :
                     first_data_pointer_q + 16'h0001;
               end
            end
         end
         if (end_edge && core_bus) begin
            o_done <= 1'b1;
            o_rdata <= data_q;
            o_ready <= 1'b1;
         end
         case (host_q)
            HOST_IDLE: begin
               if (i_host_req && !busy && !pend_q) begin // [R19]
                  o_periph_addr <= i_host_addr;
                  o_periph_wdata <= i_host_wdata;
                  o_periph_wr <= i_host_wr;
                  o_periph_rd <= ~i_host_wr;
                  host_q <= HOST_WAIT;
               end
            end
            HOST_WAIT: begin
               o_periph_rd <= 1'b0;
               o_host_rdata <= i_periph_rdata; // [R19]
               o_host_ack <= 1'b1;
               host_q <= HOST_ACK;
            end
            HOST_ACK: begin
               if (!i_host_req) begin
                  host_q <= HOST_IDLE;
               end
            end
            default: host_q <= HOST_IDLE;
         endcase
      end
   end

endmodule

/* File: logic/core_regs.vh */
`ifndef CORE_REGS_VH
`define CORE_REGS_VH

// Special register offsets for the dual data pointers.
`define ADDR_PTR0_LOW 8'h82
`define ADDR_PTR0_HIGH 8'h83
`define ADDR_PTR1_LOW 8'h84
`define ADDR_PTR1_HIGH 8'h85
`define ADDR_PTR_SEL 8'h86
`define SEL_BIT 0
`define SEL_RESET 1'b0
`define DP_RESET 16'h0000

// Program space and external data space layout.
`define CODE_RESET 16'h0000
`define XSRAM_BASE 16'h0000
`define XSRAM_SIZE 16'h0400
`define XFLASH_BASE 16'h8000
`define XFLASH_SIZE 16'h0800

// Timing counts.
`define SYS_DIV 2
`define LAST_PHASE 2'h3
`define TMR_SLOW 4'hC
`define TMR_FAST 4'h4

// Operation codes on the request port.
`define OP_NOP 4'h0
`define OP_DIR_RD 4'h1
`define OP_DIR_WR 4'h2
`define OP_IND_RD 4'h3
`define OP_IND_WR 4'h4
`define OP_DIR_INC 4'h5
`define OP_PTR_LOAD 4'h6
`define OP_PTR_INC 4'h7
`define OP_XDATA_RD 4'h8
`define OP_XDATA_WR 4'h9
`define OP_MOV_DD 4'hA
`define OP_MULTIPLY 4'hB

`endif

/* File: logic/cycle_sequencer.v */
`timescale 1ns/100ps
`include "core_regs.vh"

module cycle_sequencer (
   input wire i_clk,
   input wire i_rst,
   input wire i_start,
   input wire [2:0] i_cycles,
   output reg o_tick,
   output reg [1:0] o_phase,
   output reg o_busy,
   output reg [2:0] o_icycle,
   output reg o_last
);

   always @(posedge i_clk) begin
      if (i_rst) begin
         o_tick <= 1'b0;
         o_phase <= 2'h0;
         o_busy <= 1'b0;
         o_icycle <= 3'h0;
         o_last <= 1'b0;
      end else begin
         o_tick <= ~o_tick; // [R14]
         if (o_tick) begin
            o_phase <= o_phase + 2'h1; // [R13]
            if (o_phase == `LAST_PHASE) begin
               if (i_start) begin
                  o_busy <= 1'b1;
                  o_icycle <= 3'h0;
                  o_last <= (i_cycles == 3'h1);
               end else if (o_busy && !o_last) begin
                  o_icycle <= o_icycle + 3'h1;
                  o_last <= ((o_icycle + 3'h2) == i_cycles); // [R16]
               end else begin
                  o_busy <= 1'b0;
                  o_last <= 1'b0;
               end
            end
         end
      end
   end

endmodule

/* File: logic/timer_prescaler.v */
`timescale 1ns/100ps
`include "core_regs.vh"

module timer_prescaler (
   input wire i_clk,
   input wire i_rst,
   input wire i_tick,
   input wire i_fast,
   output reg o_tick
);

   reg [3:0] cnt_q;
   wire [3:0] limit;

   assign limit = i_fast ? `TMR_FAST : `TMR_SLOW;

   always @(posedge i_clk) begin
      if (i_rst) begin
         cnt_q <= 4'h0;
         o_tick <= 1'b0;
      end else begin
         o_tick <= 1'b0;
         if (i_tick) begin
            if (cnt_q >= limit - 4'h1) begin // [R18]
               cnt_q <= 4'h0;
               o_tick <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 4'h1;
            end
         end
      end
   end

endmodule
